//--- inc/ssi_cfg.svh
/*
 * Offsets, field positions, opcodes and reset values of the
 * halt / subtract execution block.
 * Assumes a 32-bit AHB-Lite slave decoding haddr[11:0].
 */
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH

// register byte offsets
`define SSI_OFF_INSTR 12'h000
`define SSI_OFF_ACC 12'h004
`define SSI_OFF_STATUS 12'h008
`define SSI_OFF_WDOG 12'h00c
`define SSI_OFF_PRESC 12'h010
// file registers: 128 words from 0x200
`define SSI_FILE_SEL 3'h1
`define SSI_FILE_SEL_HI 11
`define SSI_FILE_SEL_LO 9

// instruction encodings (14-bit words)
`define SSI_OP_HALT 14'h0063
`define SSI_LIT_SUB_PAT 5'h1e
`define SSI_FILE_SUB_PAT 6'h02
`define SSI_DEST_BIT 7

// software-writable status bits: carry, half carry, zero
`define SSI_STAT_SW_MASK 6'h07
`define SSI_NIB_MASK 8'h0f

// reset values
`define SSI_RST_STATUS 6'h18
`define SSI_RST_BYTE 8'h00
`define SSI_RST_INSTR 14'h0000
`define SSI_RST_WORD 32'h0000_0000

`endif

//--- inc/ssi_pkg.sv
/*
 * Types shared by the halt / subtract execution block.
 * Assumes ssi_cfg.svh for all numeric constants.
 */
package ssi_pkg;

  typedef enum logic [1:0] {
    OP_NONE, OP_HALT, OP_LIT_SUB, OP_FILE_SUB
  } ssi_op_type;

  // bit 0 carry ... bit 5 halted
  typedef struct packed {
    logic halted;
    logic wd_expiry;
    logic sleep_entered;
    logic zero;
    logic half_carry;
    logic carry;
  } ssi_status_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
  } ssi_aphase_type;

  typedef struct packed {
    logic [7:0] diff;
    logic carry;
    logic half_carry;
    logic zero;
  } ssi_sub_type;

endpackage : ssi_pkg

//--- logic/ssi_core.sv
/*
 * Executes the halt, literal_minus_acc and file_minus_acc instructions
 * written into the instruction register over AHB-Lite.
 * Assumes one AHB-Lite master, single word transfers, hready from
 * this slave's hreadyout.
 */
// How it works
// - halt word 0x0063 clears sleep_entered_flag.
// - halt: watchdog_expiry_flag set, watchdog_counter, prescaler zero.
// - after halt the core stops; no later instruction executes.
// - literal_minus_acc puts literal minus accumulator into accumulator.
// - file_minus_acc computes file register minus accumulator.
// - destination bit 0: result to accumulator, file register kept.
// - destination bit 1: result written back to file register.
// - both subtracts set carry when the difference is positive.
// - both subtracts set carry when the difference is zero.
// - both subtracts clear carry on a borrow out of bit 7.
`timescale 1ns/10ps
`include "ssi_cfg.svh"

module ssi_core (
  input wire logic ref_clk_i, // 200 MHz core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic hsel_i, // slave select
  input wire logic [31:0] haddr_i, // byte address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic [2:0] hsize_i, // word only, not decoded
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic [31:0] hrdata_o, // read data
  output logic hreadyout_o, // slave ready
  output logic hresp_o, // always OKAY
  output logic halted_o // halted, oscillator stopped
);
  import ssi_pkg::*;

  ssi_aphase_type ap_r, ap_nxt;
  ssi_status_type stat_r, stat_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] wdog_r, wdog_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic [13:0] instr_r, instr_nxt;
  logic [7:0] file_mem [0:127];
  logic file_we;
  logic [6:0] file_wa, file_ra, ex_fidx;
  logic [7:0] file_wd, opnd;
  logic ex_go, dest_file;
  ssi_op_type op;
  ssi_sub_type sub;

  function automatic ssi_op_type decode(input logic [13:0] w);
    ssi_op_type o;
    o = OP_NONE;
    if (w == `SSI_OP_HALT) begin
      o = OP_HALT;
    end else if (w[13:9] == `SSI_LIT_SUB_PAT) begin
      o = OP_LIT_SUB;
    end else if (w[13:8] == `SSI_FILE_SUB_PAT) begin
      o = OP_FILE_SUB;
    end
    return o;
  endfunction : decode

  function automatic ssi_sub_type sub8(input logic [7:0] a,
                                       input logic [7:0] b);
    ssi_sub_type s;
    logic [8:0] d9;
    logic [4:0] d5;
    d9 = {1'b0, a} - {1'b0, b};
    d5 = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    s.diff = d9[7:0];
    s.carry = ~d9[8];
    s.half_carry = ~d5[4];
    s.zero = (d9[7:0] == 8'h00);
    return s;
  endfunction : sub8

  function automatic logic is_file(input logic [11:0] a);
    return a[`SSI_FILE_SEL_HI:`SSI_FILE_SEL_LO] == `SSI_FILE_SEL;
  endfunction : is_file

  assign ex_fidx = hwdata_i[6:0];
  assign dest_file = hwdata_i[`SSI_DEST_BIT];
  assign file_ra = ap_r.rd ? ap_r.addr[8:2] : ex_fidx;
  assign op = decode(hwdata_i[13:0]);
  // halted core executes no further instruction writes; instr_r still takes them
  assign ex_go = ap_r.wr && (ap_r.addr == `SSI_OFF_INSTR)
                 && !stat_r.halted;
  assign opnd = (op == OP_LIT_SUB) ? hwdata_i[7:0] : file_mem[file_ra];
  assign sub = sub8(opnd, acc_r);

  always_comb begin
    ap_nxt = '0;
    ready_nxt = 1'b1;
    rdata_nxt = rdata_r;
    acc_nxt = acc_r;
    stat_nxt = stat_r;
    wdog_nxt = wdog_r;
    pre_nxt = pre_r;
    instr_nxt = instr_r;
    file_we = 1'b0;
    file_wa = ap_r.addr[8:2];
    file_wd = hwdata_i[7:0];
    // address phase; reads get one wait state
    if (hsel_i && htrans_i[1] && hready_i) begin
      ap_nxt.wr = hwrite_i;
      ap_nxt.rd = !hwrite_i;
      ap_nxt.addr = haddr_i[11:0];
      ready_nxt = hwrite_i;
    end
    if (ap_r.rd) begin
      rdata_nxt = `SSI_RST_WORD;
      if (is_file(ap_r.addr)) begin
        rdata_nxt[7:0] = file_mem[file_ra];
      end else begin
        case (ap_r.addr)
          `SSI_OFF_INSTR: rdata_nxt[13:0] = instr_r;
          `SSI_OFF_ACC: rdata_nxt[7:0] = acc_r;
          `SSI_OFF_STATUS: rdata_nxt[5:0] = stat_r;
          `SSI_OFF_WDOG: rdata_nxt[7:0] = wdog_r;
          `SSI_OFF_PRESC: rdata_nxt[7:0] = pre_r;
          default: rdata_nxt = `SSI_RST_WORD;
        endcase
      end
    end
    if (ap_r.wr) begin
      if (is_file(ap_r.addr)) begin
        file_we = 1'b1;
      end else begin
        case (ap_r.addr)
          `SSI_OFF_INSTR: instr_nxt = hwdata_i[13:0];
          `SSI_OFF_ACC: acc_nxt = hwdata_i[7:0];
          `SSI_OFF_STATUS: begin
            stat_nxt = ssi_status_type'((stat_r & ~`SSI_STAT_SW_MASK)
                       | (hwdata_i[5:0] & `SSI_STAT_SW_MASK));
          end
          `SSI_OFF_WDOG: wdog_nxt = hwdata_i[7:0];
          `SSI_OFF_PRESC: pre_nxt = hwdata_i[7:0];
          default: ;
        endcase
      end
    end
    if (ex_go) begin
      case (op)
        OP_HALT: begin
          stat_nxt.sleep_entered = 1'b0;
          stat_nxt.wd_expiry = 1'b1;
          wdog_nxt = `SSI_RST_BYTE;
          pre_nxt = `SSI_RST_BYTE;
          stat_nxt.halted = 1'b1;
        end
        OP_LIT_SUB, OP_FILE_SUB: begin
          stat_nxt.carry = sub.carry;
          stat_nxt.half_carry = sub.half_carry;
          stat_nxt.zero = sub.zero;
          if (op == OP_FILE_SUB && dest_file) begin
            file_we = 1'b1;
            file_wa = ex_fidx;
            file_wd = sub.diff;
          end else begin
            acc_nxt = sub.diff;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_r <= '0;
      ready_r <= 1'b1;
      rdata_r <= `SSI_RST_WORD;
      acc_r <= `SSI_RST_BYTE;
      stat_r <= `SSI_RST_STATUS;
      wdog_r <= `SSI_RST_BYTE;
      pre_r <= `SSI_RST_BYTE;
      instr_r <= `SSI_RST_INSTR;
    end else begin
      ap_r <= ap_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
      acc_r <= acc_nxt;
      stat_r <= stat_nxt;
      wdog_r <= wdog_nxt;
      pre_r <= pre_nxt;
      instr_r <= instr_nxt;
    end
  end

  // file registers hold no reset value
  always_ff @(posedge ref_clk_i) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  assign hrdata_o = rdata_r;
  assign hreadyout_o = ready_r;
  assign hresp_o = 1'b0;
  assign halted_o = stat_r.halted;

  sequence halt_seq;
    ex_go && op == OP_HALT;
  endsequence
  sequence lit_seq;
    ex_go && op == OP_LIT_SUB;
  endsequence
  sequence fsub_seq;
    ex_go && op == OP_FILE_SUB;
  endsequence
  sequence sub_seq;
    ex_go && (op == OP_LIT_SUB || op == OP_FILE_SUB);
  endsequence

  halt_sleep_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    halt_seq |=> !stat_r.sleep_entered)
    else $error("halt left sleep flag set");
  halt_wdog_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    halt_seq |=> stat_r.wd_expiry && wdog_r == `SSI_RST_BYTE
      && pre_r == `SSI_RST_BYTE)
    else $error("halt did not clear watchdog");
  halt_stop_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    halt_seq |=> halted_o [*4])
    else $error("core left halt");
  // software may still write status over the bus while halted
  halted_freeze_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    stat_r.halted && !(ap_r.wr && ap_r.addr == `SSI_OFF_STATUS)
      |=> $stable(stat_r.carry) && $stable(stat_r.zero)
      && $stable(stat_r.half_carry))
    else $error("halted core changed flags");
  lit_result_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    lit_seq |=> acc_r == 8'($past(opnd) - $past(acc_r)))
    else $error("literal subtract wrong");
  file_acc_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fsub_seq ##0 !dest_file |=> acc_r == 8'($past(opnd) - $past(acc_r)))
    else $error("file subtract to acc wrong");
  file_back_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fsub_seq ##0 dest_file |=> $stable(acc_r) &&
      file_mem[$past(ex_fidx)] == 8'($past(opnd) - $past(acc_r)))
    else $error("file write-back wrong");
  carry_pos_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sub_seq ##0 (opnd > acc_r) |=> stat_r.carry)
    else $error("carry clear on positive");
  carry_zero_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sub_seq ##0 (opnd == acc_r) |=> stat_r.carry)
    else $error("carry clear on zero");
  borrow_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sub_seq ##0 (opnd < acc_r) |=> !stat_r.carry)
    else $error("carry set on borrow");
  zero_flag_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sub_seq |=> stat_r.zero == ($past(opnd) == $past(acc_r)))
    else $error("zero flag wrong");
  half_carry_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    sub_seq |=> stat_r.half_carry == (($past(opnd) & `SSI_NIB_MASK)
      >= ($past(acc_r) & `SSI_NIB_MASK)))
    else $error("half carry wrong");

endmodule : ssi_core

//--- testbench/sleep_and_subtract_instr_bench.sv
/*
 * Self-checking bench for ssi_core: subtracts, halt, status readback.
 * Assumes ssi_cfg.svh and ssi_pkg; the bench is the only bus master.
 */
`timescale 1ns/10ps
`include "ssi_cfg.svh"

module sleep_and_subtract_instr_bench;
  import ssi_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic halted;
  logic hresp;
  logic rd_dp = 1'b0;
  logic [31:0] exp_q[$];
  logic [7:0] acc_m;
  logic [5:0] st_m = `SSI_RST_STATUS;
  int unsigned seed = 82286;
  int err_count = 0;
  int total_checks = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  ssi_core dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .halted_o(halted)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic ssi_sub_type sub_f(input logic [7:0] a, b);
    ssi_sub_type r;
    r.diff = a - b;
    r.carry = a >= b;
    r.half_carry = a[3:0] >= b[3:0];
    r.zero = r.diff == 8'h00;
    return r;
  endfunction : sub_f

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge ref_clk_i);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  // read data phase ends where hreadyout is high again
  always @(posedge ref_clk_i) begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1)
      rd_dp <= htrans[1] && !hwrite;
  end

  task automatic do_sub(input logic fop, input logic d, input logic eq);
    logic [7:0] a;
    logic [7:0] v;
    logic [6:0] f;
    ssi_sub_type r;
    a = rnd();
    v = rnd();
    f = 7'(rnd());
    if (eq)
      a = v;
    r = sub_f(v, a);
    xfer(`SSI_OFF_ACC, 1'b1, {24'h0, a});
    if (fop) begin
      xfer(12'h200 + {f, 2'b00}, 1'b1, {24'h0, v});
      xfer(`SSI_OFF_INSTR, 1'b1, {18'h0, `SSI_FILE_SUB_PAT, d, f});
    end else begin
      xfer(`SSI_OFF_INSTR, 1'b1, {18'h0, `SSI_LIT_SUB_PAT, f[0], v});
    end
    acc_m = (fop && d) ? a : r.diff;
    st_m[2:0] = {r.zero, r.half_carry, r.carry};
    rd(`SSI_OFF_ACC, {24'h0, acc_m});
    if (fop)
      rd(12'h200 + {f, 2'b00}, {24'h0, d ? r.diff : v});
    rd(`SSI_OFF_STATUS, {26'h0, st_m});
    rd(`SSI_OFF_STATUS, {26'h0, st_m});
  endtask : do_sub

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(`SSI_OFF_STATUS, {26'h0, `SSI_RST_STATUS});
    rd(12'h100, 32'h0);
    $display("test reset and unmapped done");
    for (int i = 0; i < 16; i++)
      do_sub(1'b0, 1'b0, i % 4 == 0);
    $display("test literal_minus_acc done");
    for (int i = 0; i < 16; i++)
      do_sub(1'b1, i[0], i % 4 < 2);
    $display("test file_minus_acc done");
    check({31'h0, halted}, 32'h0);
    xfer(`SSI_OFF_WDOG, 1'b1, 32'h5a);
    xfer(`SSI_OFF_PRESC, 1'b1, 32'h3c);
    xfer(`SSI_OFF_INSTR, 1'b1, {18'h0, `SSI_OP_HALT});
    st_m[5:3] = 3'b110;
    rd(`SSI_OFF_STATUS, {26'h0, st_m});
    rd(`SSI_OFF_WDOG, 32'h0);
    rd(`SSI_OFF_PRESC, 32'h0);
    check({31'h0, halted}, 32'h1);
    // a subtract after halt must leave the accumulator alone
    xfer(`SSI_OFF_INSTR, 1'b1, {18'h0, `SSI_LIT_SUB_PAT, 1'b0, 8'h77});
    rd(`SSI_OFF_ACC, {24'h0, acc_m});
    rd(`SSI_OFF_STATUS, {26'h0, st_m});
    $display("test halt done");
    repeat (3) @(posedge ref_clk_i);
    conclude();
  end
endmodule : sleep_and_subtract_instr_bench
